// file: src/position_error_clear_and_gear.sv
// Position command front end: electronic gear scaling of reference steps,
// position error counter and its clear policies, APB register slave.
// Assumes reference and feedback steps arrive already decoded on clk, and
// that the clear, servo-on, overtravel and zero clamp levels come from pins.
`default_nettype none

module position_error_clear_and_gear
    import gear_pkg::*;
#(
    parameter int CNT_W = 32
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic deviation_reset_input_n,
    input wire logic servo_on,
    input wire logic overtravel,
    input wire logic zero_clamp,
    input wire step_t ref_in,
    output logic ref_ready,
    input wire step_t fb_in,
    output step_t cmd_out,
    output logic loop_run,
    output logic signed [CNT_W-1:0] correction
);

    if (CNT_W < 8 || CNT_W > 32) begin : g_bad_width
        $error("CNT_W must lie between 8 and 32");
    end

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [3:0] pins_raw;
    logic [3:0] s1_q;
    logic [3:0] s2_q;
    logic [3:0] s3_q;
    logic [3:0] pin_q;

    assign pins_raw = {zero_clamp, overtravel, servo_on,
                       deviation_reset_input_n};

    always_ff @(posedge clk) begin
        if (rst) begin
            s1_q <= PIN_IDLE;
            s2_q <= PIN_IDLE;
            s3_q <= PIN_IDLE;
        end else begin
            s1_q <= pins_raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // A level is accepted only when two stages agree, so a single glitch
    // near a sampling edge never reaches the counter.
    for (genvar i = 0; i < 4; i++) begin : g_pin
        always_ff @(posedge clk) begin
            if (rst) begin
                pin_q[i] <= PIN_IDLE[i];
            end else if (s2_q[i] == s3_q[i]) begin
                pin_q[i] <= s3_q[i];
            end
        end
    end

    logic clr_active;
    logic srv_on;
    logic ot_active;
    logic zc_active;

    assign clr_active = ~pin_q[0];
    assign srv_on = pin_q[1];
    assign ot_active = pin_q[2];
    assign zc_active = pin_q[3];

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    logic width_q;
    logic [1:0] policy_q;
    logic [15:0] num_short_q;
    logic [15:0] den_short_q;
    logic [15:0] num_high_q;
    logic [15:0] num_low_q;
    logic [15:0] den_high_q;
    logic [15:0] den_low_q;
    logic wr_access;
    logic rd_setup;
    logic mapped;
    logic value_ok;
    logic wr_ok;
    logic restart;
    logic [15:0] wval;

    assign pready = 1'b1;
    assign wr_access = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign wval = pwdata[15:0];

    always_comb begin
        mapped = 1'b1;
        value_ok = 1'b1;
        case (paddr)
            ADDR_CONTROL: value_ok = pwdata[2:1] != 2'h3;
            ADDR_COMMAND: value_ok = 1'b1;
            ADDR_NUM_SHORT, ADDR_DEN_SHORT: begin
                value_ok = pwdata[31:16] == 16'h0000 && wval >= SHORT_MIN;
            end
            ADDR_NUM_HIGH, ADDR_DEN_HIGH: begin
                value_ok = pwdata[31:16] == 16'h0000 && wval <= PART_MAX;
            end
            ADDR_NUM_LOW, ADDR_DEN_LOW: begin
                value_ok = pwdata[31:16] == 16'h0000 && wval >= PART_MIN
                    && wval <= PART_MAX;
            end
            ADDR_ERROR, ADDR_STATUS: value_ok = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    assign wr_ok = wr_access && mapped && value_ok;
    assign pslverr = psel && penable && (!mapped || (pwrite && !value_ok));
    assign restart = wr_ok && paddr == ADDR_COMMAND
        && pwdata[CMD_RESTART_BIT];

    always_ff @(posedge clk) begin
        if (rst) begin
            width_q <= RST_WIDTH;
            policy_q <= RST_POLICY;
        end else if (wr_ok && paddr == ADDR_CONTROL) begin
            width_q <= pwdata[CTRL_WIDTH_BIT];
            policy_q <= pwdata[CTRL_POLICY_LSB +: 2];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            num_short_q <= RST_SHORT;
            den_short_q <= RST_SHORT;
            num_high_q <= RST_HIGH;
            num_low_q <= RST_LOW;
            den_high_q <= RST_HIGH;
            den_low_q <= RST_LOW;
        end else if (wr_ok) begin
            case (paddr)
                ADDR_NUM_SHORT: num_short_q <= wval;
                ADDR_DEN_SHORT: den_short_q <= wval;
                ADDR_NUM_HIGH: num_high_q <= wval;
                ADDR_NUM_LOW: num_low_q <= wval;
                ADDR_DEN_HIGH: den_high_q <= wval;
                ADDR_DEN_LOW: den_low_q <= wval;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Active gear ratio
    // ------------------------------------------------------------------
    logic [GEAR_W-1:0] num_wide;
    logic [GEAR_W-1:0] den_wide;
    logic [GEAR_W-1:0] num_act_q;
    logic [GEAR_W-1:0] den_act_q;
    logic wide_act_q;

    assign num_wide = GEAR_W'(num_high_q) * GEAR_SCALE
        + GEAR_W'(num_low_q);
    assign den_wide = GEAR_W'(den_high_q) * GEAR_SCALE
        + GEAR_W'(den_low_q);

    // Register writes only stage new operands; the running ratio changes
    // at a restart, so a ratio is never half updated mid-move.
    always_ff @(posedge clk) begin
        if (rst) begin
            num_act_q <= GEAR_W'(RST_SHORT);
            den_act_q <= GEAR_W'(RST_SHORT);
            wide_act_q <= RST_WIDTH;
        end else if (restart) begin
            wide_act_q <= width_q;
            if (width_q == WIDTH_SHORT) begin
                num_act_q <= GEAR_W'(num_short_q);
                den_act_q <= GEAR_W'(den_short_q);
            end else begin
                num_act_q <= num_wide;
                den_act_q <= den_wide;
            end
        end
    end

    // ------------------------------------------------------------------
    // Clear policy
    // ------------------------------------------------------------------
    logic purge;

    always_comb begin
        case (policy_q)
            PURGE_ON_OFF: purge = !srv_on;
            PURGE_ON_OFF_OT: purge = (!srv_on || ot_active) && !zc_active;
            default: purge = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // Gear engine
    // ------------------------------------------------------------------
    logic signed [RES_W-1:0] res_q;
    logic signed [RES_W-1:0] num_s;
    logic signed [RES_W-1:0] den_s;
    logic cmd_up;
    logic cmd_dn;
    logic zero_all;

    assign num_s = signed'({2'b00, num_act_q});
    assign den_s = signed'({2'b00, den_act_q});
    assign cmd_up = res_q >= den_s;
    assign cmd_dn = res_q <= -den_s;
    assign ref_ready = !cmd_up && !cmd_dn;
    assign zero_all = clr_active || purge;

    // The residue holds B times steps minus A times increments issued, so
    // the fractional part survives between reference steps. A new step
    // waits until the previous one has been spent.
    always_ff @(posedge clk) begin
        if (rst || zero_all) begin
            res_q <= '0;
        end else if (cmd_up) begin
            res_q <= res_q - den_s;
        end else if (cmd_dn) begin
            res_q <= res_q + den_s;
        end else if (ref_in.step) begin
            res_q <= ref_in.dir ? res_q - num_s : res_q + num_s;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cmd_out <= '0;
        end else begin
            cmd_out.step <= cmd_up || cmd_dn;
            cmd_out.dir <= cmd_dn;
        end
    end

    // ------------------------------------------------------------------
    // Error counter and loop gate
    // ------------------------------------------------------------------
    logic signed [CNT_W-1:0] err_q;
    logic signed [CNT_W-1:0] err_d;
    logic signed [CNT_W-1:0] delta;

    always_comb begin
        delta = '0;
        if (cmd_up) begin
            delta = delta + CNT_W'(1);
        end else if (cmd_dn) begin
            delta = delta - CNT_W'(1);
        end
        if (fb_in.step) begin
            delta = fb_in.dir ? delta + CNT_W'(1) : delta - CNT_W'(1);
        end
        err_d = err_q + delta;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            err_q <= '0;
        end else if (clr_active) begin
            err_q <= '0;
        end else if (purge) begin
            err_q <= '0;
        end else begin
            err_q <= err_d;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            loop_run <= 1'b0;
            correction <= '0;
        end else begin
            loop_run <= srv_on && !clr_active;
            correction <= (srv_on && !clr_active) ? err_q : '0;
        end
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            prdata <= '0;
        end else if (rd_setup) begin
            case (paddr)
                ADDR_CONTROL: prdata <= {29'h0, policy_q, width_q};
                ADDR_NUM_SHORT: prdata <= {16'h0, num_short_q};
                ADDR_DEN_SHORT: prdata <= {16'h0, den_short_q};
                ADDR_NUM_HIGH: prdata <= {16'h0, num_high_q};
                ADDR_NUM_LOW: prdata <= {16'h0, num_low_q};
                ADDR_DEN_HIGH: prdata <= {16'h0, den_high_q};
                ADDR_DEN_LOW: prdata <= {16'h0, den_low_q};
                ADDR_ERROR: prdata <= 32'(err_q);
                ADDR_STATUS: begin
                    prdata <= '0;
                    prdata[STAT_LOOP_BIT] <= loop_run;
                    prdata[STAT_CLEAR_BIT] <= clr_active;
                    prdata[STAT_WIDE_BIT] <= wide_act_q;
                    prdata[STAT_READY_BIT] <= ref_ready;
                end
                default: prdata <= '0;
            endcase
        end
    end

endmodule

`default_nettype wire

// file: src/gear_pkg.sv
// Constants, register map and carrier types of the position command front
// end. Assumes a 32-bit APB register bus and a single 10 MHz clock.
`default_nettype none

package gear_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_COMMAND = 8'h04;
    localparam logic [7:0] ADDR_NUM_SHORT = 8'h08;
    localparam logic [7:0] ADDR_DEN_SHORT = 8'h0c;
    localparam logic [7:0] ADDR_NUM_HIGH = 8'h10;
    localparam logic [7:0] ADDR_NUM_LOW = 8'h14;
    localparam logic [7:0] ADDR_DEN_HIGH = 8'h18;
    localparam logic [7:0] ADDR_DEN_LOW = 8'h1c;
    localparam logic [7:0] ADDR_ERROR = 8'h20;
    localparam logic [7:0] ADDR_STATUS = 8'h24;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CTRL_WIDTH_BIT = 0;
    localparam int CTRL_POLICY_LSB = 1;
    localparam int CMD_RESTART_BIT = 0;
    localparam int STAT_LOOP_BIT = 0;
    localparam int STAT_CLEAR_BIT = 1;
    localparam int STAT_WIDE_BIT = 2;
    localparam int STAT_READY_BIT = 3;

    // ------------------------------------------------------------------
    // Clear policies and ratio width codes
    // ------------------------------------------------------------------
    localparam logic [1:0] PURGE_ON_OFF = 2'h0;
    localparam logic [1:0] PURGE_NEVER = 2'h1;
    localparam logic [1:0] PURGE_ON_OFF_OT = 2'h2;
    localparam logic WIDTH_SHORT = 1'b0;

    // ------------------------------------------------------------------
    // Reset values and limits
    // ------------------------------------------------------------------
    localparam logic [1:0] RST_POLICY = PURGE_ON_OFF;
    localparam logic RST_WIDTH = WIDTH_SHORT;
    localparam logic [15:0] RST_SHORT = 16'h0001;
    localparam logic [15:0] RST_HIGH = 16'h0000;
    localparam logic [15:0] RST_LOW = 16'h0001;
    localparam logic [15:0] SHORT_MIN = 16'h0001;
    localparam logic [15:0] PART_MIN = 16'h0001;
    localparam logic [15:0] PART_MAX = 16'h270f;
    localparam int GEAR_W = 27;
    localparam logic [GEAR_W-1:0] GEAR_SCALE = 27'h2710;
    localparam int RES_W = GEAR_W + 2;
    localparam logic [3:0] PIN_IDLE = 4'h1;

    // One step of a position stream; dir high means reverse.
    typedef struct packed {
        logic step;
        logic dir;
    } step_t;

endpackage

`default_nettype wire

// file: dv/gear_asserts.sv
// Checker for the position command front end, bound to its top module.
// Assumes the register map and pin filtering of gear_pkg.
`default_nettype none
module gear_asserts
    import gear_pkg::*;
#(
    parameter int CNT_W = 32
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pslverr,
    input wire logic deviation_reset_input_n,
    input wire logic servo_on,
    input wire step_t cmd_out,
    input wire logic loop_run,
    input wire logic signed [CNT_W-1:0] correction
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic wr;
    logic sh;
    logic hi;
    logic lo;
    assign wr = psel && penable && pwrite;
    assign sh = paddr == ADDR_NUM_SHORT || paddr == ADDR_DEN_SHORT;
    assign hi = paddr == ADDR_NUM_HIGH || paddr == ADDR_DEN_HIGH;
    assign lo = paddr == ADDR_NUM_LOW || paddr == ADDR_DEN_LOW;
    // Eight samples cover the pin filter plus the output register.
    sequence clr_held;
        (!deviation_reset_input_n)[*8];
    endsequence
    sequence off_held;
        (!servo_on)[*8];
    endsequence
    chk_clear_zero:
    assert property (clr_held |-> correction == '0)
        else $error("correction not zero while cleared");
    chk_clear_halt:
    assert property (clr_held |-> !loop_run && !cmd_out.step)
        else $error("loop active while cleared");
    chk_off_halt:
    assert property (off_held |-> !loop_run)
        else $error("loop active with servo off");
    chk_short_zero:
    assert property (wr && sh && pwdata == 32'h0 |-> pslverr)
        else $error("zero short operand accepted");
    chk_short_ok:
    assert property (wr && sh && pwdata inside {[32'h1:32'hffff]}
        |-> !pslverr)
        else $error("valid short operand refused");
    chk_high_range:
    assert property (wr && hi && pwdata > {16'h0, PART_MAX} |-> pslverr)
        else $error("oversized high part accepted");
    chk_high_ok:
    assert property (wr && hi && pwdata <= {16'h0, PART_MAX} |-> !pslverr)
        else $error("valid high part refused");
    chk_low_range:
    assert property (wr && lo && (pwdata == 32'h0
        || pwdata > {16'h0, PART_MAX}) |-> pslverr)
        else $error("bad low part accepted");
endmodule
bind position_error_clear_and_gear gear_asserts #(.CNT_W(CNT_W))
    i_gear_asserts (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pslverr(pslverr), .deviation_reset_input_n(deviation_reset_input_n),
    .servo_on(servo_on), .cmd_out(cmd_out), .loop_run(loop_run),
    .correction(correction));
`default_nettype wire

// file: dv/ref_pulse_host.sv
// Host controller model issuing reference steps to the front end.
// Assumes one clock; a step is held until ref_ready is seen high.
`default_nettype none
module ref_pulse_host
    import gear_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire logic [7:0] count,
    input wire logic rev,
    input wire logic [3:0] gap,
    input wire logic ref_ready,
    output var step_t ref_in,
    output logic busy
);
    logic [7:0] left_q;
    logic [3:0] gap_q;
    assign busy = left_q != 8'h00;
    always_ff @(posedge clk) begin
        if (rst) begin
            ref_in <= '0;
            left_q <= 8'h00;
            gap_q <= 4'h0;
        end else if (start) begin
            left_q <= count;
            ref_in.dir <= rev;
        end else if (ref_in.step) begin
            if (ref_ready) begin
                ref_in.step <= 1'b0;
                left_q <= left_q - 8'h01;
                gap_q <= gap;
                // Idle direction flips so a stale level is never trusted.
                if (left_q == 8'h01) begin
                    ref_in.dir <= ~ref_in.dir;
                end
            end
        end else if (gap_q != 4'h0) begin
            gap_q <= gap_q - 4'h1;
        end else if (left_q != 8'h00) begin
            ref_in.step <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// file: dv/test_position_error_clear_and_gear.sv
// Self-checking bench for the position command front end.
// Assumes gear_pkg, the host model and the bound checker.
`default_nettype none
module test_position_error_clear_and_gear
    import gear_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, clr_n = 1'b1, servo_on = 1'b0;
    logic overtravel = 1'b0, zero_clamp = 1'b0, start = 1'b0, rev = 1'b0;
    logic [7:0] paddr = 8'h00, count = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdata;
    logic [3:0] gap = 4'h0;
    logic pready, pslverr, ref_ready, loop_run, busy;
    step_t ref_in, cmd_out, fb_in = '0;
    logic signed [31:0] correction;
    int fail_count = 0, total_checks = 0, cyc = 0, cmd_cnt = 0, c0;
    always #50 clk = ~clk;
    position_error_clear_and_gear i_position_error_clear_and_gear (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .deviation_reset_input_n(clr_n), .servo_on(servo_on),
        .overtravel(overtravel), .zero_clamp(zero_clamp), .ref_in(ref_in),
        .ref_ready(ref_ready), .fb_in(fb_in), .cmd_out(cmd_out),
        .loop_run(loop_run), .correction(correction));
    ref_pulse_host i_ref_pulse_host (.clk(clk), .rst(rst), .start(start),
        .count(count), .rev(rev), .gap(gap), .ref_ready(ref_ready),
        .ref_in(ref_in), .busy(busy));
    always @(posedge clk) begin
        cyc++;
        if (cmd_out.step === 1'b1) cmd_cnt += cmd_out.dir ? -1 : 1;
        if (cyc == 20000) begin
            fail_count++;
            finish_test();
        end
    end
    task automatic chk(string n, logic [31:0] e, logic [31:0] s);
        total_checks++;
        if (s !== e) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d, logic e);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rdata = prdata;
        chk("pslverr", {31'h0, e}, {31'h0, pslverr});
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] e, logic err);
        apb(1'b0, a, 32'h0, err);
        chk($sformatf("register %h", a), e, rdata);
    endtask
    task automatic pins(logic c, logic s, logic o, logic z);
        clr_n <= c;
        servo_on <= s;
        overtravel <= o;
        zero_clamp <= z;
        repeat (10) @(posedge clk);
    endtask
    task automatic send(logic [7:0] n, logic r, logic [3:0] g);
        c0 = cmd_cnt;
        start <= 1'b1;
        count <= n;
        rev <= r;
        gap <= g;
        @(posedge clk);
        start <= 1'b0;
        @(posedge clk);
        while (busy === 1'b1) @(posedge clk);
        repeat (8) @(posedge clk);
    endtask
    task automatic t_defaults();
        logic [7:0] a[6] = '{ADDR_NUM_SHORT, ADDR_DEN_SHORT, ADDR_NUM_HIGH,
            ADDR_NUM_LOW, ADDR_DEN_HIGH, ADDR_DEN_LOW};
        logic [31:0] v[6] = '{32'h1, 32'h1, 32'h0, 32'h1, 32'h0, 32'h1};
        for (int i = 0; i < 6; i++) rd(a[i], v[i], 1'b0);
        rd(8'h28, 32'h0, 1'b1);
    endtask
    task automatic t_ranges();
        apb(1'b1, ADDR_NUM_SHORT, 32'h0, 1'b1);
        apb(1'b1, ADDR_NUM_SHORT, 32'hffff, 1'b0);
        rd(ADDR_NUM_SHORT, 32'hffff, 1'b0);
        apb(1'b1, ADDR_NUM_HIGH, 32'h2710, 1'b1);
        apb(1'b1, ADDR_NUM_HIGH, 32'h0, 1'b0);
        apb(1'b1, ADDR_NUM_LOW, 32'h0, 1'b1);
        apb(1'b1, ADDR_NUM_LOW, 32'h270f, 1'b0);
        apb(1'b1, ADDR_CONTROL, 32'h6, 1'b1);
    endtask
    task automatic t_short();
        pins(1'b1, 1'b1, 1'b0, 1'b0);
        apb(1'b1, ADDR_NUM_SHORT, 32'h3, 1'b0);
        apb(1'b1, ADDR_DEN_SHORT, 32'h2, 1'b0);
        send(8'd4, 1'b0, 4'h0);
        chk("steps before restart", 32'd4, cmd_cnt - c0);
        apb(1'b1, ADDR_COMMAND, 32'h1, 1'b0);
        send(8'd4, 1'b0, 4'h3);
        chk("scaled steps", 32'd6, cmd_cnt - c0);
        rd(ADDR_ERROR, 32'd10, 1'b0);
        fb_in <= '{step: 1'b1, dir: 1'b0};
        repeat (10) @(posedge clk);
        fb_in <= '0;
        rd(ADDR_ERROR, 32'd0, 1'b0);
        chk("correction", 32'h0, correction);
    endtask
    task automatic t_wide();
        apb(1'b1, ADDR_CONTROL, 32'h1, 1'b0);
        apb(1'b1, ADDR_NUM_HIGH, 32'h1, 1'b0);
        apb(1'b1, ADDR_NUM_LOW, 32'h2, 1'b0);
        apb(1'b1, ADDR_DEN_LOW, 32'h1389, 1'b0);
        apb(1'b1, ADDR_COMMAND, 32'h1, 1'b0);
        rd(ADDR_STATUS, 32'hd, 1'b0);
        send(8'd3, 1'b1, 4'h0);
        chk("composite steps", -32'sd6, cmd_cnt - c0);
        rd(ADDR_ERROR, 32'hfffffffa, 1'b0);
        chk("correction", 32'hfffffffa, correction);
        fb_in <= '{step: 1'b1, dir: 1'b1};
        repeat (3) @(posedge clk);
        fb_in <= '0;
        rd(ADDR_ERROR, 32'hfffffffd, 1'b0);
    endtask
    task automatic t_clear();
        pins(1'b0, 1'b1, 1'b0, 1'b0);
        chk("loop_run", 32'h0, {31'h0, loop_run});
        chk("correction", 32'h0, correction);
        rd(ADDR_ERROR, 32'h0, 1'b0);
        pins(1'b1, 1'b1, 1'b0, 1'b0);
        chk("loop_run", 32'h1, {31'h0, loop_run});
    endtask
    task automatic t_policy();
        logic [4:0] c[6] = '{5'b00000, 5'b01000, 5'b10000, 5'b00100,
            5'b10100, 5'b10110};
        logic gone[6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, ADDR_CONTROL, {29'h0, c[i][4:3], 1'b1}, 1'b0);
            pins(1'b0, 1'b1, 1'b0, 1'b0);
            pins(1'b1, 1'b1, 1'b0, 1'b0);
            send(8'd2, 1'b0, 4'h1);
            // Bit 2 raises servo-on and overtravel, bit 1 the zero clamp.
            pins(1'b1, c[i][2], c[i][2], c[i][1]);
            rd(ADDR_ERROR, gone[i] ? 32'h0 : 32'h4, 1'b0);
        end
    endtask
    task automatic finish_test();
        if (fail_count == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_defaults();
        t_ranges();
        t_short();
        t_wide();
        t_clear();
        t_policy();
        finish_test();
    end
endmodule
`default_nettype wire
